// [src/afepm_defines.svh]
`ifndef AFEPM_DEFINES_SVH
`define AFEPM_DEFINES_SVH

// Register addresses (seven-bit, ahead of the read/write bit)
`define AFEPM_REG_TOP       7'h00
`define AFEPM_REG_CHPD      7'h01
`define AFEPM_REG_OVLD      7'h02
`define AFEPM_REG_PLL       7'h03
`define AFEPM_REG_GAIN      7'h0a
`define AFEPM_REG_EQ        7'h0b
`define AFEPM_REG_HALF      7'h1a

// Field positions
`define AFEPM_TOP_PD_BIT    0
`define AFEPM_TOP_SLEEP_BIT 1
`define AFEPM_TOP_RATE_BIT  4
`define AFEPM_OVLD_IOR_BIT  4
`define AFEPM_PLL_BW_BIT    1
`define AFEPM_GAIN_CGS_BIT  7
`define AFEPM_EQ_ON_BIT     4
`define AFEPM_HALF_DIS_BIT  3

// Reset values
`define AFEPM_RST_VAL       8'h00

// Recommended settings written by the host
`define AFEPM_REC_TOP       8'h10
`define AFEPM_REC_OVLD      8'h10

// Timing
`define AFEPM_CLK_NS        5
`define AFEPM_RST_MS        10
`define AFEPM_RST_CYC       ((`AFEPM_RST_MS * 1000000) / `AFEPM_CLK_NS)
`define AFEPM_SCLK_HALF     4'h4

// Host APB register offsets
`define AFEPM_APB_CTRL      12'h000
`define AFEPM_APB_ADDR      12'h004
`define AFEPM_APB_WDATA     12'h008
`define AFEPM_APB_RDATA     12'h00c
`define AFEPM_APB_STAT      12'h010
`define AFEPM_APB_PINS      12'h014

`endif

// [src/afepm_pkg.sv]
package afepm_pkg;
	typedef enum logic [1:0] {
		AFEPM_MODE_IMAGING = 2'b00,
		AFEPM_MODE_DOPPLER = 2'b01
	} afepm_mode_t;
	typedef enum logic [2:0] {
		AFEPM_H_IDLE  = 3'b000,
		AFEPM_H_SHIFT = 3'b001,
		AFEPM_H_DONE  = 3'b010,
		AFEPM_H_RSTA  = 3'b011,
		AFEPM_H_RSTW  = 3'b100
	} afepm_hstate_t;
endpackage

// [src/afepm_link_if.sv]
`timescale 1ns/10ps
interface afepm_link_if;
	logic sclk;
	logic conv_cs_n;
	logic dio_host_o;
	logic dio_host_oe;
	logic dio_dev_o;
	logic dio_dev_oe;
	logic dio;
	logic conv_reset_n;
	logic amp_reset;
	logic amp_supply_en;
	logic converter_mode_select_pin;
	logic amplifier_mode_select_pin;
	// Shared data wire, pulled high when undriven
	assign dio = dio_host_oe ? dio_host_o : (dio_dev_oe ? dio_dev_o : 1'b1);
	modport dev (
		input  sclk, conv_cs_n, dio, conv_reset_n, amp_reset,
		input  converter_mode_select_pin, amplifier_mode_select_pin,
		output dio_dev_o, dio_dev_oe
	);
	modport host (
		output sclk, conv_cs_n, dio_host_o, dio_host_oe, conv_reset_n, amp_reset,
		output amp_supply_en, converter_mode_select_pin, amplifier_mode_select_pin,
		input  dio
	);
endinterface

// [src/afepm_device.sv]
`timescale 1ns/10ps
`include "afepm_defines.svh"
// Behaviour
// - Global power-down bit stops whole converter
// - Power-down kills PLL, reference, bias; slow wake
// - Sleep bit puts converter to sleep
// - Mode pin also sleeps converter, fast wake
// - Eight per-channel power-down bits
// - Mode pins select imaging or Doppler
// - Host pulses converter reset 10 ms, waits 10 ms
// - Host enables overload recovery bit
// - Host selects 40/40.5 MSPS rate bit
// - Listed bits reset to zero
// - Three-wire serial port, shared data line
// - Converter reset low, amp reset high, async
module afepm_device (
	// System clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Link
	afepm_link_if.dev          link,
	// Power state
	output logic               conv_power_down,
	output logic               conv_sleep,
	output logic               pll_ref_bias_on,
	output logic [7:0]         chan_off,
	output logic               preamp_power_down,
	output logic               var_gain_power_down,
	output logic               doppler_demod_on,
	output logic               rate_40m_sel,
	output logic               overload_recovery_enable,
	output logic               pll_bandwidth_select,
	output logic               gain_auto_select,
	output logic               equalizer_on,
	output logic               half_step_disable,
	output afepm_pkg::afepm_mode_t mode
);
	logic [2:0]  sclk_s_q, sclk_s_d;
	logic [2:0]  cs_s_q, cs_s_d;
	logic [2:0]  dio_s_q, dio_s_d;
	logic [2:0]  cmp_s_q, cmp_s_d;
	logic [2:0]  amp_s_q, amp_s_d;
	logic        sclk_f_q, sclk_f_d, cs_f_q, cs_f_d, dio_f_q, dio_f_d;
	logic        cmp_f_q, cmp_f_d, amp_f_q, amp_f_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [15:0] sh_q, sh_d;
	logic [7:0]  top_q, top_d, chpd_q, chpd_d, ovld_q, ovld_d, pll_q, pll_d;
	logic [7:0]  gain_q, gain_d, eq_q, eq_d, half_q, half_d;
	logic [7:0]  rd_q, rd_d;
	logic        oe_q, oe_d, dout_q, dout_d;
	logic        rise, fall, arst_n;
	logic [6:0]  addr;

	// Async reset of the serial section
	// both reset pins
	assign arst_n = presetn & link.conv_reset_n & ~link.amp_reset;

	always_comb begin
		sclk_s_d = {sclk_s_q[1:0], link.sclk};
		cs_s_d   = {cs_s_q[1:0], link.conv_cs_n};
		dio_s_d  = {dio_s_q[1:0], link.dio};
		cmp_s_d  = {cmp_s_q[1:0], link.converter_mode_select_pin};
		amp_s_d  = {amp_s_q[1:0], link.amplifier_mode_select_pin};
		sclk_f_d = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_f_q;
		cs_f_d   = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_f_q;
		dio_f_d  = (dio_s_q[1] == dio_s_q[2]) ? dio_s_q[2] : dio_f_q;
		cmp_f_d  = (cmp_s_q[1] == cmp_s_q[2]) ? cmp_s_q[2] : cmp_f_q;
		amp_f_d  = (amp_s_q[1] == amp_s_q[2]) ? amp_s_q[2] : amp_f_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_s_q <= 3'h0;
			cs_s_q   <= 3'h7;
			dio_s_q  <= 3'h7;
			cmp_s_q  <= 3'h0;
			amp_s_q  <= 3'h0;
			sclk_f_q <= 1'b0;
			cs_f_q   <= 1'b1;
			dio_f_q  <= 1'b1;
			cmp_f_q  <= 1'b0;
			amp_f_q  <= 1'b0;
		end else begin
			sclk_s_q <= sclk_s_d;
			cs_s_q   <= cs_s_d;
			dio_s_q  <= dio_s_d;
			cmp_s_q  <= cmp_s_d;
			amp_s_q  <= amp_s_d;
			sclk_f_q <= sclk_f_d;
			cs_f_q   <= cs_f_d;
			dio_f_q  <= dio_f_d;
			cmp_f_q  <= cmp_f_d;
			amp_f_q  <= amp_f_d;
		end
	end

	assign rise = sclk_f_d & ~sclk_f_q;
	assign fall = ~sclk_f_d & sclk_f_q;
	// After eight rises the address and direction sit in the low byte
	assign addr = sh_q[7:1];

	always_comb begin
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		oe_d   = oe_q;
		dout_d = dout_q;
		rd_d   = rd_q;
		top_d  = top_q;
		chpd_d = chpd_q;
		ovld_d = ovld_q;
		pll_d  = pll_q;
		gain_d = gain_q;
		eq_d   = eq_q;
		half_d = half_q;
		if (cs_f_q) begin
			cnt_d = 5'h00;
			oe_d  = 1'b0;
		end else begin
			if (rise && cnt_q < 5'h10) begin
				sh_d  = {sh_q[14:0], dio_f_q};
				cnt_d = cnt_q + 5'h01;
			end
			if (fall && cnt_q == 5'h08 && sh_q[0]) begin
				unique case (addr)
					`AFEPM_REG_TOP:  rd_d = top_q;
					`AFEPM_REG_CHPD: rd_d = chpd_q;
					`AFEPM_REG_OVLD: rd_d = ovld_q;
					`AFEPM_REG_PLL:  rd_d = pll_q;
					`AFEPM_REG_GAIN: rd_d = gain_q;
					`AFEPM_REG_EQ:   rd_d = eq_q;
					`AFEPM_REG_HALF: rd_d = half_q;
					default:         rd_d = 8'h00;
				endcase
				oe_d   = 1'b1;
				dout_d = rd_d[7];
			end else if (fall && oe_q && cnt_q > 5'h08 && cnt_q < 5'h10) begin
				rd_d   = {rd_q[6:0], 1'b0};
				dout_d = rd_d[7];
			end
			// registers change only on a full write
			if (rise && cnt_q == 5'h0f && !sh_q[7]) begin
				unique case (sh_q[14:8])
					`AFEPM_REG_TOP:  top_d  = {sh_q[6:0], dio_f_q};
					`AFEPM_REG_CHPD: chpd_d = {sh_q[6:0], dio_f_q};
					`AFEPM_REG_OVLD: ovld_d = {sh_q[6:0], dio_f_q};
					`AFEPM_REG_PLL:  pll_d  = {sh_q[6:0], dio_f_q};
					`AFEPM_REG_GAIN: gain_d = {sh_q[6:0], dio_f_q};
					`AFEPM_REG_EQ:   eq_d   = {sh_q[6:0], dio_f_q};
					`AFEPM_REG_HALF: half_d = {sh_q[6:0], dio_f_q};
					default:         top_d  = top_q;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q  <= 5'h00;
			sh_q   <= 16'h0000;
			oe_q   <= 1'b0;
			dout_q <= 1'b0;
			rd_q   <= `AFEPM_RST_VAL;
			top_q  <= `AFEPM_RST_VAL;
			chpd_q <= `AFEPM_RST_VAL;
			ovld_q <= `AFEPM_RST_VAL;
			pll_q  <= `AFEPM_RST_VAL;
			gain_q <= `AFEPM_RST_VAL;
			eq_q   <= `AFEPM_RST_VAL;
			half_q <= `AFEPM_RST_VAL;
		end else begin
			cnt_q  <= cnt_d;
			sh_q   <= sh_d;
			oe_q   <= oe_d;
			dout_q <= dout_d;
			rd_q   <= rd_d;
			top_q  <= top_d;
			chpd_q <= chpd_d;
			ovld_q <= ovld_d;
			pll_q  <= pll_d;
			gain_q <= gain_d;
			eq_q   <= eq_d;
			half_q <= half_d;
		end
	end

	assign link.dio_dev_o  = dout_q;
	assign link.dio_dev_oe = oe_q;

	assign mode = cmp_f_q ? afepm_pkg::AFEPM_MODE_DOPPLER : afepm_pkg::AFEPM_MODE_IMAGING;
	assign doppler_demod_on    = amp_f_q;
	assign preamp_power_down   = 1'b0;
	assign var_gain_power_down = amp_f_q;
	assign conv_power_down = top_q[`AFEPM_TOP_PD_BIT];
	assign pll_ref_bias_on = ~top_q[`AFEPM_TOP_PD_BIT];
	assign conv_sleep = ~top_q[`AFEPM_TOP_PD_BIT] & (top_q[`AFEPM_TOP_SLEEP_BIT] | cmp_f_q);
	assign chan_off = chpd_q | {8{top_q[`AFEPM_TOP_PD_BIT]}};
	assign rate_40m_sel             = top_q[`AFEPM_TOP_RATE_BIT];
	assign overload_recovery_enable = ovld_q[`AFEPM_OVLD_IOR_BIT];
	assign pll_bandwidth_select     = pll_q[`AFEPM_PLL_BW_BIT];
	assign gain_auto_select         = gain_q[`AFEPM_GAIN_CGS_BIT];
	assign equalizer_on             = eq_q[`AFEPM_EQ_ON_BIT];
	assign half_step_disable        = half_q[`AFEPM_HALF_DIS_BIT];
endmodule

// [src/afepm_host.sv]
`timescale 1ns/10ps
`include "afepm_defines.svh"
module afepm_host #(
	parameter int unsigned RST_CYC = `AFEPM_RST_CYC
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// Link
	afepm_link_if.host         link
);
	afepm_pkg::afepm_hstate_t st_q, st_d;
	logic [6:0]  addr_q, addr_d;
	logic [7:0]  wd_q, wd_d, rdat_q, rdat_d;
	logic [15:0] sh_q, sh_d;
	logic [4:0]  bit_q, bit_d;
	logic [3:0]  div_q, div_d;
	logic        rd_q, rd_d, sclk_q, sclk_d, cs_q, cs_d, oe_q, oe_d, done_q, done_d;
	logic [31:0] tmr_q, tmr_d;
	logic        rstn_q, rstn_d, supen_q, supen_d, amprst_q, amprst_d;
	logic [1:0]  pins_q, pins_d;
	logic [2:0]  din_s_q;
	logic        acc, wr, busy;

	assign acc  = psel & penable;
	assign wr   = acc & pwrite;
	assign busy = (st_q != afepm_pkg::AFEPM_H_IDLE) && (st_q != afepm_pkg::AFEPM_H_DONE);
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	always_comb begin
		unique case (paddr)
			`AFEPM_APB_ADDR:  prdata = {25'h0, addr_q};
			`AFEPM_APB_WDATA: prdata = {24'h0, wd_q};
			`AFEPM_APB_RDATA: prdata = {24'h0, rdat_q};
			`AFEPM_APB_STAT:  prdata = {29'h0, supen_q, done_q, busy};
			`AFEPM_APB_PINS:  prdata = {28'h0, amprst_q, rstn_q, pins_q};
			default:          prdata = 32'h0;
		endcase
	end

	always_comb begin
		st_d = st_q; addr_d = addr_q; wd_d = wd_q; rdat_d = rdat_q; sh_d = sh_q;
		bit_d = bit_q; div_d = div_q; rd_d = rd_q; sclk_d = sclk_q; cs_d = cs_q;
		oe_d = oe_q; done_d = done_q; tmr_d = tmr_q; rstn_d = rstn_q;
		supen_d = supen_q; amprst_d = amprst_q; pins_d = pins_q;
		if (wr && paddr == `AFEPM_APB_ADDR)  addr_d = pwdata[6:0];
		if (wr && paddr == `AFEPM_APB_WDATA) wd_d = pwdata[7:0];
		if (wr && paddr == `AFEPM_APB_PINS) begin
			pins_d   = pwdata[1:0];
			amprst_d = pwdata[3];
			supen_d  = pwdata[4];
		end
		unique case (st_q)
			afepm_pkg::AFEPM_H_IDLE, afepm_pkg::AFEPM_H_DONE: begin
				if (wr && paddr == `AFEPM_APB_CTRL && pwdata[0]) begin
					rd_d  = pwdata[1];
					sh_d  = {addr_d, pwdata[1], wd_d};
					cs_d  = 1'b0;
					oe_d  = 1'b1;
					bit_d = 5'h00;
					div_d = 4'h0;
					done_d = 1'b0;
					st_d  = afepm_pkg::AFEPM_H_SHIFT;
				end else if (wr && paddr == `AFEPM_APB_CTRL && pwdata[2]) begin
					rstn_d  = 1'b0;
					supen_d = 1'b0;
					tmr_d   = 32'h0;
					done_d  = 1'b0;
					st_d    = afepm_pkg::AFEPM_H_RSTA;
				end
			end
			afepm_pkg::AFEPM_H_SHIFT: begin
				div_d = div_q + 4'h1;
				if (div_q == `AFEPM_SCLK_HALF - 4'h1) begin
					div_d  = 4'h0;
					sclk_d = ~sclk_q;
					if (sclk_q) begin
						// Sample read data late, past the device's pin filter
						if (bit_q > 5'h07 && rd_q) rdat_d = {rdat_q[6:0], din_s_q[2]};
						bit_d = bit_q + 5'h01;
						sh_d  = {sh_q[14:0], 1'b0};
						if (bit_q == 5'h07 && rd_q) oe_d = 1'b0;
						if (bit_q == 5'h0f) begin
							cs_d   = 1'b1;
							oe_d   = 1'b0;
							done_d = 1'b1;
							st_d   = afepm_pkg::AFEPM_H_DONE;
						end
					end
				end
			end
			afepm_pkg::AFEPM_H_RSTA: begin
				tmr_d = tmr_q + 32'h1;
				if (tmr_q == RST_CYC - 1) begin
					rstn_d = 1'b1;
					tmr_d  = 32'h0;
					st_d   = afepm_pkg::AFEPM_H_RSTW;
				end
			end
			afepm_pkg::AFEPM_H_RSTW: begin
				tmr_d = tmr_q + 32'h1;
				if (tmr_q == RST_CYC - 1) begin
					supen_d = 1'b1;
					done_d  = 1'b1;
					st_d    = afepm_pkg::AFEPM_H_DONE;
				end
			end
			default: st_d = afepm_pkg::AFEPM_H_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= afepm_pkg::AFEPM_H_IDLE;
			addr_q <= 7'h00; wd_q <= 8'h00; rdat_q <= 8'h00; sh_q <= 16'h0000;
			bit_q <= 5'h00; div_q <= 4'h0; rd_q <= 1'b0; sclk_q <= 1'b0;
			cs_q <= 1'b1; oe_q <= 1'b0; done_q <= 1'b0; tmr_q <= 32'h0;
			rstn_q <= 1'b1; supen_q <= 1'b0; amprst_q <= 1'b0; pins_q <= 2'h0;
			din_s_q <= 3'h0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d; wd_q <= wd_d; rdat_q <= rdat_d; sh_q <= sh_d;
			bit_q <= bit_d; div_q <= div_d; rd_q <= rd_d; sclk_q <= sclk_d;
			cs_q <= cs_d; oe_q <= oe_d; done_q <= done_d; tmr_q <= tmr_d;
			rstn_q <= rstn_d; supen_q <= supen_d; amprst_q <= amprst_d; pins_q <= pins_d;
			din_s_q <= {din_s_q[1:0], link.dio};
		end
	end

	assign link.sclk         = sclk_q;
	assign link.conv_cs_n    = cs_q;
	assign link.dio_host_o   = sh_q[15];
	assign link.dio_host_oe  = oe_q;
	assign link.conv_reset_n = rstn_q;
	assign link.amp_reset    = amprst_q;
	assign link.amp_supply_en = supen_q;
	assign link.converter_mode_select_pin = pins_q[0];
	assign link.amplifier_mode_select_pin = pins_q[1];
endmodule

// [tb/afepm_assertions.sv]
`timescale 1ns/10ps
module afepm_assertions #(
	parameter int unsigned RST_CYC = 50
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	input wire logic sclk,
	input wire logic conv_cs_n,
	input wire logic dio_host_oe,
	input wire logic dio_dev_oe,
	input wire logic conv_reset_n,
	input wire logic amp_supply_en
);
	logic [31:0] lo_q, lo_d, hi_q, hi_d;
	logic [4:0]  ck_q, ck_d;
	logic        sc_q;
	always_comb begin
		lo_d = conv_reset_n ? 32'h0 : lo_q + 32'h1;
		hi_d = !conv_reset_n ? 32'h0 : (amp_supply_en ? hi_q : hi_q + 32'h1);
		ck_d = conv_cs_n ? 5'h0 : ck_q + {4'h0, sclk & !sc_q};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_q <= 32'h0;
			hi_q <= 32'h0;
			ck_q <= 5'h0;
			sc_q <= 1'b0;
		end else begin
			lo_q <= lo_d;
			hi_q <= hi_d;
			ck_q <= ck_d;
			sc_q <= sclk;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	no_contention_a: assert property (!(dio_host_oe && dio_dev_oe))
		else $error("Both ends drive data");
	idle_release_a: assert property (conv_cs_n [*6] |-> !dio_dev_oe)
		else $error("Device drives while deselected");
	sclk_idle_a: assert property (conv_cs_n && $past(conv_cs_n) |-> !sclk)
		else $error("Serial clock runs outside frame");
	half_period_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("Serial clock high time wrong");
	frame_len_a: assert property ($rose(conv_cs_n) |-> ck_q == 5'd16)
		else $error("Frame not sixteen clocks");
	turnaround_a: assert property ($rose(dio_dev_oe) |-> ck_q == 5'd8)
		else $error("Device drives at wrong bit");
	reset_pulse_a: assert property ($rose(conv_reset_n) |-> lo_q == RST_CYC)
		else $error("Converter reset pulse length wrong");
	supply_wait_a: assert property ($rose(amp_supply_en) |-> hi_q == RST_CYC)
		else $error("Supply enabled at wrong time");
	cover property ($rose(amp_supply_en));
	cover property ($rose(dio_dev_oe));
	cover property ($rose(conv_cs_n));
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, r;
	logic                   conv_power_down, conv_sleep, pll_ref_bias_on;
	logic                   var_gain_power_down, doppler_demod_on;
	logic                   rate_40m_sel, overload_recovery_enable;
	logic [7:0]             chan_off, d;
	logic                   pll_bandwidth_select, gain_auto_select, equalizer_on;
	logic                   half_step_disable, preamp_power_down;
	afepm_pkg::afepm_mode_t mode;
	int                     miscompares, n_compared;
	afepm_link_if link ();
	afepm_host #(.RST_CYC(50)) afepm_host_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link.host));
	afepm_device afepm_device_i (.pclk, .presetn, .link(link.dev), .conv_power_down,
		.conv_sleep, .pll_ref_bias_on, .chan_off, .preamp_power_down,
		.var_gain_power_down, .doppler_demod_on, .rate_40m_sel,
		.overload_recovery_enable, .pll_bandwidth_select, .gain_auto_select,
		.equalizer_on, .half_step_disable, .mode);
	afepm_assertions #(.RST_CYC(50)) afepm_assertions_i (.pclk, .presetn,
		.sclk(link.sclk), .conv_cs_n(link.conv_cs_n), .dio_host_oe(link.dio_host_oe),
		.dio_dev_oe(link.dio_dev_oe), .conv_reset_n(link.conv_reset_n),
		.amp_supply_en(link.amp_supply_en));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			chk(32'h0, 32'h1);
			stop_test;
		end
		r = prdata;
		chk({31'h0, pslverr}, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task idle;
		int n;
		for (n = 0; n < 400; n++) begin
			apb(1'b0, 12'h010, 32'h0);
			if (r[0] === 1'b0) break;
		end
		if (n == 400) begin
			chk(32'h0, 32'h1);
			stop_test;
		end
	endtask
	task lwr(input logic [6:0] a, input logic [7:0] v);
		apb(1'b1, 12'h004, {25'h0, a});
		apb(1'b1, 12'h008, {24'h0, v});
		apb(1'b1, 12'h000, 32'h1);
		idle;
	endtask
	task lrd(input logic [6:0] a);
		apb(1'b1, 12'h004, {25'h0, a});
		apb(1'b1, 12'h000, 32'h3);
		idle;
		apb(1'b0, 12'h00c, 32'h0);
		d = r[7:0];
	endtask
	task pins(input logic [31:0] v, input logic dop);
		int n;
		apb(1'b1, 12'h014, v);
		for (n = 0; n < 20 && (mode[0] !== dop || doppler_demod_on !== dop); n++)
			@(posedge pclk);
		if (mode[0] !== dop || doppler_demod_on !== dop) begin
			chk(32'h0, 32'h1);
			stop_test;
		end
	endtask
	task t_defaults;
		logic [6:0] ra[7];
		ra = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h0a, 7'h0b, 7'h1a};
		foreach (ra[i]) begin
			lrd(ra[i]);
			chk(d, 32'h0);
		end
		chk({pll_bandwidth_select, gain_auto_select, equalizer_on, half_step_disable}, 32'h0);
		$display("t_defaults done");
	endtask
	task t_power;
		lwr(7'h00, 8'h01);
		chk(conv_power_down, 32'h1);
		chk(pll_ref_bias_on, 32'h0);
		lwr(7'h01, 8'ha5);
		chk(chan_off, 32'hff);
		lrd(7'h01);
		chk(d, 32'ha5);
		chk(conv_power_down, 32'h1);
		lwr(7'h00, 8'h12);
		chk(conv_sleep, 32'h1);
		chk(pll_ref_bias_on, 32'h1);
		chk(rate_40m_sel, 32'h1);
		chk(chan_off, 32'ha5);
		lwr(7'h0b, 8'h10);
		chk(equalizer_on, 32'h1);
		lwr(7'h02, 8'h10);
		chk(overload_recovery_enable, 32'h1);
		lwr(7'h00, 8'h00);
		chk(conv_sleep, 32'h0);
		$display("t_power done");
	endtask
	task t_pins;
		pins(32'h3, 1'b1);
		chk(mode, afepm_pkg::AFEPM_MODE_DOPPLER);
		chk(conv_sleep, 32'h1);
		chk(var_gain_power_down, 32'h1);
		chk(preamp_power_down, 32'h0);
		pins(32'h0, 1'b0);
		chk(mode, afepm_pkg::AFEPM_MODE_IMAGING);
		chk({conv_sleep, doppler_demod_on}, 32'h0);
		$display("t_pins done");
	endtask
	task t_resets;
		lwr(7'h01, 8'h3c);
		apb(1'b1, 12'h014, 32'h8);
		apb(1'b1, 12'h014, 32'h0);
		lrd(7'h01);
		chk(d, 32'h0);
		lwr(7'h01, 8'h3c);
		apb(1'b1, 12'h000, 32'h4);
		idle;
		chk(r[2:1], 32'h3);
		chk(chan_off, 32'h0);
		chk(equalizer_on, 32'h0);
		$display("t_resets done");
	endtask
	initial begin
		miscompares = 0;
		n_compared = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults;
		t_power;
		t_pins;
		t_resets;
		stop_test;
	end
endmodule
